// ### xbs_defs.svh
// How it works
// - Bits 2:0 report the fixed function number; reads as zero after reset.
// - Each write addressing the bridge loads bits 7:3 from address lines 15:11.
// - Addressed means config write, select asserted, type-0 low bits, function match.
// - Bits 15:8 mirror the primary bus number, read-only, reset to all ones.
// - Completer ID for split completions is built from bus, device, function.
// - Bits 16 and 17 read as zero and ignore writes.
// - Bits 18 and 20 read as zero permanently.
// - Bit 19 sets on completion matching own ID; write one clears; resets zero.
// - Bit 21 sets when a split request is delayed by the limit; write-one-clear.
// - Commitment limit counts ADQs and resets to sixteen.
`ifndef XBS_DEFS_SVH
`define XBS_DEFS_SVH

// Register placement in configuration space
`define XBS_OFF_STATUS  8'h84
`define XBS_REG_IDX     6'h21
`define XBS_AD_IDX      7:2
`define XBS_AD_TYPE     1:0
`define XBS_AD_FUNC     10:8
`define XBS_AD_DEV      15:11
`define XBS_TYPE0       2'h0

// Field positions of the status word
`define XBS_F_FUNC      2:0
`define XBS_F_DEV       7:3
`define XBS_F_BUS       15:8
`define XBS_B_UNEXP     19
`define XBS_B_DELAY     21
`define XBS_F_FIXED     18:16
`define XBS_B_OVRN      20
`define XBS_F_RSVD      31:22
`define XBS_BE_FLAGS    2

// Fixed and reset values
`define XBS_FUNC_NUM    3'h0
`define XBS_DEV_RST     5'h00
`define XBS_BUS_RST     8'hFF
`define XBS_LIM_RST     16'h0010
`define XBS_LIM_ALL     16'hFFFF
`define XBS_ZERO16      16'h0000
`define XBS_ZERO32      32'h0000_0000

`endif

// ### xbs_pkg.sv
package xbs_pkg;

    // Configuration transaction as seen at the address phase
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        idsel;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0]  be;
    } xbs_cfg_t;

    // Split completion arriving on the primary side
    typedef struct packed {
        logic        valid;
        logic [15:0] req_id;
    } xbs_cpl_t;

    // Split request or retirement, sized in ADQs
    typedef struct packed {
        logic        valid;
        logic [15:0] adq;
    } xbs_split_t;

    // State of one write-one-to-clear flag
    typedef struct packed {
        logic flag;
    } xbs_flag_state_t;

    // State of the status block
    typedef struct packed {
        logic [4:0]  dev;
        logic [7:0]  bus;
        logic [15:0] limit;
        logic [15:0] outst;
        logic [31:0] rdata;
        logic        rvalid;
        logic [15:0] cid;
        logic        fwd;
        logic        dly;
    } xbs_state_t;

endpackage : xbs_pkg

// ### xbs_w1c_flag.sv
`timescale 1ns/100ps
`include "xbs_defs.svh"

module xbs_w1c_flag
    import xbs_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Event and software clear
    input  wire logic set,
    input  wire logic clr,
    // Flag value
    output logic      flag
);

    xbs_flag_state_t s_q;
    xbs_flag_state_t s_d;

    // Set beats clear so an event in the clearing cycle is kept
    always_comb begin
        s_d = s_q;
        if (set) begin
            s_d.flag = 1'b1;
        end else if (clr) begin
            s_d.flag = 1'b0;
        end
    end

    // Synchronous reset to a cleared flag
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign flag = s_q.flag;

    property p_set_wins;
        @(posedge mclk) disable iff (!rst_n) set |=> flag;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag lost an event");

endmodule : xbs_w1c_flag

// ### xbs_status.sv
`timescale 1ns/100ps
`include "xbs_defs.svh"

module xbs_status
    import xbs_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Configuration transactions from the primary bus
    input  wire xbs_cfg_t    cfg,
    output logic             rd_valid,
    output logic [31:0]      rd_data,
    // Primary bus number and commitment limit from their own registers
    input  wire logic [7:0]  pri_bus_num,
    input  wire logic        lim_wr,
    input  wire logic [15:0] lim_val,
    // Split traffic on the primary side
    input  wire xbs_cpl_t    cpl,
    input  wire xbs_split_t  sreq,
    input  wire xbs_split_t  sdone,
    output logic             sreq_fwd,
    output logic             sreq_dly,
    // Completer ID for split completions
    output logic [15:0]      cmpl_id
);

    xbs_state_t  s_q;
    xbs_state_t  s_d;
    logic        f_unexp;
    logic        f_delay;
    logic        hit_bridge;
    logic        addr_wr;
    logic        reg_sel;
    logic        clr_unexp;
    logic        clr_delay;
    logic        own_cpl;
    logic        over_lim;
    logic [16:0] want;
    logic [31:0] status;

    // Decode of a type-0 access aimed at our function
    assign hit_bridge = cfg.valid && cfg.idsel
                        && (cfg.addr[`XBS_AD_TYPE] == `XBS_TYPE0)
                        && (cfg.addr[`XBS_AD_FUNC] == `XBS_FUNC_NUM);
    assign addr_wr    = hit_bridge && cfg.write;
    assign reg_sel    = hit_bridge && (cfg.addr[`XBS_AD_IDX] == `XBS_REG_IDX);

    // Only a one in a lane-enabled bit clears; zeros leave flags alone
    assign clr_unexp  = reg_sel && cfg.write && cfg.be[`XBS_BE_FLAGS]
                        && cfg.wdata[`XBS_B_UNEXP];
    assign clr_delay  = reg_sel && cfg.write && cfg.be[`XBS_BE_FLAGS]
                        && cfg.wdata[`XBS_B_DELAY];

    // A completion naming our own ID was never requested by us
    assign own_cpl    = cpl.valid
                        && (cpl.req_id == {s_q.bus, s_q.dev, `XBS_FUNC_NUM});

    // Limit check; an all-ones limit lets every request through
    assign want       = {1'b0, s_q.outst} + {1'b0, sreq.adq};
    assign over_lim   = (s_q.limit != `XBS_LIM_ALL)
                        && (want > {1'b0, s_q.limit});

    // Status word; upper and fixed bits stay zero whatever is written
    always_comb begin
        status               = `XBS_ZERO32;
        status[`XBS_F_FUNC]  = `XBS_FUNC_NUM;
        status[`XBS_F_DEV]   = s_q.dev;
        status[`XBS_F_BUS]   = s_q.bus;
        status[`XBS_B_UNEXP] = f_unexp;
        status[`XBS_B_DELAY] = f_delay;
    end

    // Next state of the whole block
    always_comb begin
        s_d        = s_q;
        s_d.rvalid = 1'b0;
        s_d.fwd    = 1'b0;
        s_d.dly    = 1'b0;
        s_d.bus    = pri_bus_num;
        // Any addressed write, whichever register, teaches us our device number
        if (addr_wr) begin
            s_d.dev = cfg.addr[`XBS_AD_DEV];
        end
        // Reads return the word as it stood before this cycle
        if (reg_sel && !cfg.write) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = status;
        end
        if (lim_wr) begin
            s_d.limit = lim_val;
        end
        // Retire finished requests first, never below zero
        if (sdone.valid) begin
            s_d.outst = (sdone.adq > s_q.outst) ? `XBS_ZERO16 : s_q.outst - sdone.adq;
        end
        // A request that fits is forwarded, else it is held back and flagged
        if (sreq.valid) begin
            if (over_lim) begin
                s_d.dly = 1'b1;
            end else begin
                s_d.fwd   = 1'b1;
                s_d.outst = s_d.outst + sreq.adq;
            end
        end
        // Completer ID follows the live fields and lands one cycle after them
        s_d.cid = {s_q.bus, s_q.dev, `XBS_FUNC_NUM};
    end

    // Register the state; synchronous reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_q        <= '0;
            s_q.dev    <= `XBS_DEV_RST;
            s_q.bus    <= `XBS_BUS_RST;
            s_q.limit  <= `XBS_LIM_RST;
            s_q.outst  <= `XBS_ZERO16;
        end else begin
            s_q <= s_d;
        end
    end

    // Sticky error flags
    xbs_w1c_flag u_unexp (
        .mclk (mclk),
        .rst_n(rst_n),
        .set  (own_cpl),
        .clr  (clr_unexp),
        .flag (f_unexp)
    );

    xbs_w1c_flag u_delay (
        .mclk (mclk),
        .rst_n(rst_n),
        .set  (sreq.valid && over_lim),
        .clr  (clr_delay),
        .flag (f_delay)
    );

    // Outputs come straight from state flops
    assign rd_valid = s_q.rvalid;
    assign rd_data  = s_q.rdata;
    assign cmpl_id  = s_q.cid;
    assign sreq_fwd = s_q.fwd;
    assign sreq_dly = s_q.dly;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_func;
        rd_valid |-> (rd_data[`XBS_F_FUNC] == `XBS_FUNC_NUM);
    endproperty
    a_func: assert property (p_func) else $error("function field not zero");

    property p_dev;
        addr_wr |=> (s_q.dev == $past(cfg.addr[`XBS_AD_DEV]));
    endproperty
    a_dev: assert property (p_dev) else $error("device number not loaded");

    property p_nodev;
        (cfg.valid && cfg.write && cfg.addr[`XBS_AD_TYPE] != `XBS_TYPE0) |=> $stable(s_q.dev);
    endproperty
    a_nodev: assert property (p_nodev) else $error("device changed on type-1");

    property p_bus;
        rd_valid |-> (rd_data[`XBS_F_BUS] == $past(s_q.bus));
    endproperty
    a_bus: assert property (p_bus) else $error("bus field wrong");

    // The identity is one cycle behind; skip the edge that leaves reset
    property p_cid;
        $past(rst_n) |-> (cmpl_id == {$past(s_q.bus), $past(s_q.dev), `XBS_FUNC_NUM});
    endproperty
    a_cid: assert property (p_cid) else $error("completer id wrong");

    property p_fixed;
        rd_valid |-> (rd_data[`XBS_F_FIXED] == '0) && !rd_data[`XBS_B_OVRN];
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed bits not zero");

    property p_unexp;
        own_cpl |=> f_unexp;
    endproperty
    a_unexp: assert property (p_unexp) else $error("unexpected flag missed");

    property p_delay;
        sreq_dly |-> f_delay && !sreq_fwd;
    endproperty
    a_delay: assert property (p_delay) else $error("delay flag missed");

    property p_limit;
        sreq_fwd |-> ($past(s_q.limit) == `XBS_LIM_ALL)
                     || ($past(want) <= {1'b0, $past(s_q.limit)});
    endproperty
    a_limit: assert property (p_limit) else $error("forward exceeded limit");

    property p_keep;
        (reg_sel && cfg.write && !cfg.wdata[`XBS_B_UNEXP] && f_unexp) |=> f_unexp;
    endproperty
    a_keep: assert property (p_keep) else $error("zero write cleared flag");

    property p_upper;
        rd_valid |-> (rd_data[`XBS_F_RSVD] == '0);
    endproperty
    a_upper: assert property (p_upper) else $error("reserved bits not zero");

    c_dev: cover property (addr_wr ##[1:20] rd_valid);
    c_unexp: cover property (own_cpl ##[1:20] clr_unexp);
    c_delay: cover property (sreq_dly ##[1:20] sreq_fwd);

endmodule : xbs_status

// ### xbs_cfg_master.sv
`timescale 1ns/100ps

module xbs_cfg_master
    import xbs_pkg::*;
(
    // Clock
    input  wire logic        mclk,
    // Configuration request and its answer
    output xbs_cfg_t         cfg,
    input  wire logic        rd_valid,
    input  wire logic [31:0] rd_data
);
    xbs_cfg_t req_q = '0;

    // The request is a one-cycle strobe, so it is driven straight out
    assign cfg = req_q;

    // One transaction; afterwards address and data flip so stale values never pass for live ones
    task automatic op(input logic wr, input logic sel, input logic [31:0] a,
                      input logic [31:0] d, input logic [3:0] be,
                      output logic ok, output logic [31:0] q);
        @(posedge mclk);
        req_q <= '{valid: 1'b1, write: wr, idsel: sel, addr: a, wdata: d, be: be};
        @(posedge mclk);
        req_q <= '{valid: 1'b0, write: wr, idsel: 1'b0, addr: ~a, wdata: ~d, be: ~be};
        #1;
        ok = rd_valid;
        q  = rd_data;
    endtask : op
endmodule : xbs_cfg_master

// ### tb.sv
`timescale 1ns/100ps

`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("Error %s expected %h seen %h", what, exp, got); end end

module tb
    import xbs_pkg::*;
;
    localparam logic [31:0] ST = 32'h0000_5884;

    logic        mclk    = 1'b0;
    logic        rst_n   = 1'b0;
    xbs_cfg_t    cfg;
    logic        rd_valid;
    logic [31:0] rd_data;
    logic [7:0]  bus     = 8'hFF;
    logic        lim_wr  = 1'b0;
    logic [15:0] lim_val = 16'h0010;
    xbs_cpl_t    cpl     = '0;
    xbs_split_t  sreq    = '0;
    xbs_split_t  sdone   = '0;
    logic        sreq_fwd;
    logic        sreq_dly;
    logic [15:0] cmpl_id;
    int          n_fail  = 0;
    int          checks  = 0;
    logic        ok;
    logic [31:0] q;

    // 25 MHz clock
    always #20 mclk = ~mclk;

    xbs_status DUT (.mclk(mclk), .rst_n(rst_n), .cfg(cfg), .rd_valid(rd_valid),
        .rd_data(rd_data), .pri_bus_num(bus), .lim_wr(lim_wr), .lim_val(lim_val),
        .cpl(cpl), .sreq(sreq), .sdone(sdone), .sreq_fwd(sreq_fwd),
        .sreq_dly(sreq_dly), .cmpl_id(cmpl_id));

    xbs_cfg_master u_mst (.mclk(mclk), .cfg(cfg), .rd_valid(rd_valid), .rd_data(rd_data));

    task automatic rd_stat(input logic [31:0] exp);
        u_mst.op(1'b0, 1'b1, 32'h0000_0084, 32'h0000_0000, 4'hF, ok, q);
        `CHK("read answer", 1'b1, ok)
        `CHK("status word", exp, q)
    endtask : rd_stat

    // Writes never answer, so a stray read strobe shows up here
    task automatic wr(input logic sel, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        u_mst.op(1'b1, sel, a, d, be, ok, q);
        `CHK("write answer", 1'b0, ok)
    endtask : wr

    // Tb-driven strobes put the inverse size on the lines once released
    task automatic split(input logic [15:0] adq, input logic dly);
        @(posedge mclk);
        sreq <= {1'b1, adq};
        @(posedge mclk);
        sreq <= {1'b0, ~adq};
        #1;
        `CHK("delayed", dly, sreq_dly)
        `CHK("forwarded", ~dly, sreq_fwd)
    endtask : split

    task automatic hit(input logic [15:0] id);
        @(posedge mclk);
        cpl <= {1'b1, id};
        @(posedge mclk);
        cpl <= {1'b0, ~id};
    endtask : hit

    task automatic retire(input logic [15:0] adq);
        @(posedge mclk);
        sdone <= {1'b1, adq};
        @(posedge mclk);
        sdone <= {1'b0, ~adq};
    endtask : retire

    task automatic t_reset();
        rd_stat(32'h0000_FF00);
        `CHK("completer id", 16'hFF00, cmpl_id)
        wr(1'b1, 32'h0000_0084, 32'hFFFF_FFFF, 4'hF);
        rd_stat(32'h0000_FF00);
    endtask : t_reset

    // Near misses on function, select and type must leave the device number alone
    task automatic t_devnum();
        wr(1'b1, 32'h0000_2984, 32'h0000_0000, 4'hF);
        wr(1'b0, 32'h0000_3084, 32'h0000_0000, 4'hF);
        wr(1'b1, 32'h0000_3885, 32'h0000_0000, 4'hF);
        u_mst.op(1'b0, 1'b1, 32'h0000_0184, 32'h0000_0000, 4'hF, ok, q);
        `CHK("other function read", 1'b0, ok)
        rd_stat(32'h0000_FF00);
        wr(1'b1, 32'h0000_5800, 32'h0000_0000, 4'hF);
        rd_stat(32'h0000_FF58);
        @(posedge mclk);
        bus <= 8'h3C;
        rd_stat(32'h0000_3C58);
        `CHK("completer id", 16'h3C58, cmpl_id)
    endtask : t_devnum

    task automatic t_unexp();
        hit(16'h3C50);
        rd_stat(32'h0000_3C58);
        hit(16'h3C58);
        rd_stat(32'h0008_3C58);
        wr(1'b1, ST, 32'h0000_0000, 4'hF);
        wr(1'b1, ST, 32'h0008_0000, 4'hB);
        rd_stat(32'h0008_3C58);
        wr(1'b1, ST, 32'h0008_0000, 4'hF);
        rd_stat(32'h0000_3C58);
    endtask : t_unexp

    // Limit of sixteen: exact fit forwards, one more delays until retired
    task automatic t_delay();
        split(16'h0014, 1'b1);
        rd_stat(32'h0020_3C58);
        split(16'h0010, 1'b0);
        split(16'h0001, 1'b1);
        retire(16'h0010);
        split(16'h0001, 1'b0);
        @(posedge mclk);
        lim_wr <= 1'b1;
        lim_val <= 16'hFFFF;
        @(posedge mclk);
        lim_wr <= 1'b0;
        split(16'h0100, 1'b0);
        wr(1'b1, ST, 32'h0020_0000, 4'hF);
        rd_stat(32'h0000_3C58);
    endtask : t_delay

    task automatic wrap_up();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    // Main sequence
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_devnum();
        t_unexp();
        t_delay();
        wrap_up();
    end

    // Hang guard
    initial begin
        repeat (4000) @(posedge mclk);
        n_fail++;
        wrap_up();
    end
endmodule : tb
